// ### hdl/ppc_pkg.sv
// Constants, register map and types shared by the port pin control block.
// Assumes a single system clock and one CPU register port with bit and byte writes.
package ppc_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int NUM_PORTS = 10;
  localparam int PORT_W = 8;
  localparam int ADDR_W = 20;
  localparam int IDX_W = 4;
  localparam int P1_IDX = 0;

  typedef logic [NUM_PORTS-1:0][PORT_W-1:0] ppc_port_bus_t;
  typedef logic [NUM_PORTS-1:0][ADDR_W-1:0] ppc_port_addr_t;

  // ---------------------------------------------------------------------------
  // Register addresses, index order: ports 1,2,3,4,5,6,7,12,13,14
  // ---------------------------------------------------------------------------
  localparam ppc_port_addr_t DATA_ADDR = {
    20'hfff0e, 20'hfff0d, 20'hfff0c, 20'hfff07, 20'hfff06,
    20'hfff05, 20'hfff04, 20'hfff03, 20'hfff02, 20'hfff01};
  localparam ppc_port_addr_t DIR_ADDR = {
    20'hfff2e, 20'h00000, 20'hfff2c, 20'hfff27, 20'hfff26,
    20'hfff25, 20'hfff24, 20'hfff23, 20'hfff22, 20'hfff21};
  localparam ppc_port_addr_t PU_ADDR = {
    20'hf003e, 20'h00000, 20'hf003c, 20'hf0037, 20'h00000,
    20'hf0035, 20'hf0034, 20'hf0033, 20'h00000, 20'hf0031};
  localparam logic [ADDR_W-1:0] PORT1_INPUT_BUFFER_SELECT_ADDR = 20'hf0041;
  localparam logic [ADDR_W-1:0] PORT1_OUTPUT_DRIVE_SELECT_ADDR = 20'hf0051;

  // ---------------------------------------------------------------------------
  // Implemented bits
  // ---------------------------------------------------------------------------
  localparam ppc_port_bus_t DIR_MASK = {
    8'hff, 8'h00, 8'he1, 8'h1f, 8'h03, 8'h1f, 8'h0f, 8'h07, 8'h03, 8'hff};
  localparam ppc_port_bus_t LAT_MASK = {
    8'hff, 8'h01, 8'he1, 8'h1f, 8'h03, 8'h1f, 8'h0f, 8'h07, 8'h03, 8'hff};
  localparam ppc_port_bus_t RD_MASK = {
    8'hff, 8'h81, 8'hff, 8'h1f, 8'h03, 8'h1f, 8'h0f, 8'h07, 8'h03, 8'hff};
  localparam ppc_port_bus_t PU_MASK = {
    8'hff, 8'h00, 8'he1, 8'h1f, 8'h00, 8'h1f, 8'h0f, 8'h07, 8'h00, 8'hff};
  localparam ppc_port_bus_t DIR_FIX = {
    8'hff, 8'hfe, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam ppc_port_bus_t OD_FIX = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [PORT_W-1:0] PORT1_INPUT_BUFFER_SELECT_MASK = 8'h63;
  localparam logic [PORT_W-1:0] PORT1_OUTPUT_DRIVE_SELECT_MASK = 8'ha5;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [PORT_W-1:0] DIR_RST = 8'hff;
  localparam logic [PORT_W-1:0] LAT_RST = 8'h00;
  localparam ppc_port_bus_t PU_RST = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [PORT_W-1:0] PORT1_INPUT_BUFFER_SELECT_RST = 8'h00;
  localparam logic [PORT_W-1:0] PORT1_OUTPUT_DRIVE_SELECT_RST = 8'h00;
  localparam logic [PORT_W-1:0] RDATA_RST = 8'h00;

endpackage

// ### hdl/ppc_wr_if.sv
// Write request shared between the register file and its byte merge units.
// Assumes the source drives all signals from the CPU register port.
`timescale 1ns/100ps
interface ppc_wr_if;
  logic bit_access;
  logic [2:0] bit_sel;
  logic [7:0] wdata;

  modport src (output bit_access, output bit_sel, output wdata);
  modport dst (input bit_access, input bit_sel, input wdata);
endinterface // ppc_wr_if

// ### hdl/ppc_pin_sync.sv
// Three-stage input synchroniser with agreement filter for port pins.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/100ps
module ppc_pin_sync #(
  parameter int WIDTH = 80
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } ppc_sync_state_t;

  ppc_sync_state_t cur;
  ppc_sync_state_t next_cur;

  // ---------------------------------------------------------------------------
  // A level counts once the second and third stages agree.
  // ---------------------------------------------------------------------------
  always_comb begin
    next_cur.s1 = async_in;
    next_cur.s2 = cur.s1;
    next_cur.s3 = cur.s2;
    next_cur.q = ((cur.s2 ~^ cur.s3) & cur.s3) | ((cur.s2 ^ cur.s3) & cur.q);
    if (!rst_b) begin
      next_cur = '0;
    end
  end

  always_ff @(posedge clk) begin
    cur <= next_cur;
  end

  assign sync_out = cur.q;
endmodule // ppc_pin_sync

// ### hdl/ppc_byte_merge.sv
// Next value of one control byte under a bit or byte write.
// Assumes the caller applies the result only when the byte is addressed.
`timescale 1ns/100ps
module ppc_byte_merge (
  ppc_wr_if.dst wr,
  input wire logic [7:0] old_val,
  input wire logic [7:0] mask,
  output logic [7:0] new_val
);
  logic [7:0] req;

  // ---------------------------------------------------------------------------
  // A bit write replaces one bit, a byte write all; fixed bits never move.
  // ---------------------------------------------------------------------------
  always_comb begin
    req = old_val;
    if (wr.bit_access) begin
      req[wr.bit_sel] = wr.wdata[0];
    end else begin
      req = wr.wdata;
    end
    new_val = (old_val & ~mask) | (req & mask);
  end
endmodule // ppc_byte_merge

// ### hdl/ppc_port_control.sv
// Port pin control: direction, output latch, pull-up, input buffer and output mode.
// Assumes a CPU register port with read and write strobes on clk, and pins
// resolved outside from out and active-low output enable.
`timescale 1ns/100ps

module ppc_port_control (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ppc_pkg::ADDR_W-1:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_bit,
  input wire logic [2:0] bus_bit_sel,
  input wire logic [ppc_pkg::PORT_W-1:0] bus_wdata,
  output logic [ppc_pkg::PORT_W-1:0] bus_rdata,
  output logic bus_rvalid,
  input wire ppc_pkg::ppc_port_bus_t pin_in,
  output ppc_pkg::ppc_port_bus_t pin_out,
  output ppc_pkg::ppc_port_bus_t pin_oe_b,
  output ppc_pkg::ppc_port_bus_t pin_pullup,
  input wire ppc_pkg::ppc_port_bus_t analog_select_bit,
  input wire ppc_pkg::ppc_port_bus_t alt_out_active,
  output logic [ppc_pkg::PORT_W-1:0] input_buffer_type_bit
);
  import ppc_pkg::*;

  typedef struct packed {
    ppc_port_bus_t dir;
    ppc_port_bus_t lat;
    ppc_port_bus_t pu;
    logic [PORT_W-1:0] pim;
    logic [PORT_W-1:0] pom;
    logic [PORT_W-1:0] rdata;
    logic rvalid;
  } ppc_state_t;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_DATA,
    REG_DIR,
    REG_PU,
    REG_PIM,
    REG_POM
  } ppc_reg_kind_t;

  ppc_state_t cur;
  ppc_state_t next_cur;

  ppc_port_bus_t pin_sync;
  ppc_port_bus_t dir_eff;
  ppc_port_bus_t open_drain;
  ppc_port_bus_t rd_port;
  ppc_port_bus_t dir_new;
  ppc_port_bus_t lat_new;
  ppc_port_bus_t pu_new;
  logic [PORT_W-1:0] pim_new;
  logic [PORT_W-1:0] pom_new;
  logic [IDX_W:0] data_hit;
  logic [IDX_W:0] dir_hit;
  logic [IDX_W:0] pu_hit;
  logic [PORT_W-1:0] rd_val;
  ppc_reg_kind_t kind;
  logic [IDX_W-1:0] hit_idx;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  function automatic logic [IDX_W:0] find_port(input logic [ADDR_W-1:0] a,
                                               input ppc_port_addr_t tbl,
                                               input ppc_port_bus_t msk);
    logic [IDX_W:0] r;
    r = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (msk[i] != 8'h00 && a == tbl[i]) begin
        r = {1'b1, i[IDX_W-1:0]};
      end
    end
    return r;
  endfunction

  assign data_hit = find_port(bus_addr, DATA_ADDR, RD_MASK);
  assign dir_hit = find_port(bus_addr, DIR_ADDR, DIR_MASK);
  assign pu_hit = find_port(bus_addr, PU_ADDR, PU_MASK);

  function automatic ppc_reg_kind_t reg_kind(input logic [ADDR_W-1:0] a,
                                             input logic [IDX_W:0] dat,
                                             input logic [IDX_W:0] dir,
                                             input logic [IDX_W:0] pu);
    ppc_reg_kind_t k;
    k = REG_NONE;
    if (dat[IDX_W]) begin
      k = REG_DATA;
    end else if (dir[IDX_W]) begin
      k = REG_DIR;
    end else if (pu[IDX_W]) begin
      k = REG_PU;
    end else if (a == PORT1_INPUT_BUFFER_SELECT_ADDR) begin
      k = REG_PIM;
    end else if (a == PORT1_OUTPUT_DRIVE_SELECT_ADDR) begin
      k = REG_POM;
    end
    return k;
  endfunction

  assign kind = reg_kind(bus_addr, data_hit, dir_hit, pu_hit);

  always_comb begin
    hit_idx = '0;
    case (kind)
      REG_DATA: begin
        hit_idx = data_hit[IDX_W-1:0];
      end
      REG_DIR: begin
        hit_idx = dir_hit[IDX_W-1:0];
      end
      REG_PU: begin
        hit_idx = pu_hit[IDX_W-1:0];
      end
      default: begin
        hit_idx = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Pin functions
  // ---------------------------------------------------------------------------
  function automatic logic [PORT_W-1:0] eff_dir(input logic [PORT_W-1:0] dir,
                                                input logic [PORT_W-1:0] msk,
                                                input logic [PORT_W-1:0] fix);
    logic [PORT_W-1:0] r;
    r = (dir & msk) | (fix & ~msk);
    return r;
  endfunction

  function automatic logic [PORT_W-1:0] drive_level(input logic [PORT_W-1:0] lat,
                                                    input logic [PORT_W-1:0] od);
    logic [PORT_W-1:0] r;
    r = lat & ~od;
    return r;
  endfunction

  function automatic logic [PORT_W-1:0] drive_off_b(input logic [PORT_W-1:0] dir,
                                                    input logic [PORT_W-1:0] od,
                                                    input logic [PORT_W-1:0] lat);
    logic [PORT_W-1:0] r;
    r = dir | (od & lat);
    return r;
  endfunction

  function automatic logic [PORT_W-1:0] pull_on(input logic [PORT_W-1:0] req,
                                                input logic [PORT_W-1:0] dir,
                                                input logic [PORT_W-1:0] od,
                                                input logic [PORT_W-1:0] blk);
    logic [PORT_W-1:0] r;
    r = req & dir & ~od & ~blk;
    return r;
  endfunction

  function automatic logic [PORT_W-1:0] read_back(input logic [PORT_W-1:0] dir,
                                                  input logic [PORT_W-1:0] lat,
                                                  input logic [PORT_W-1:0] pin,
                                                  input logic [PORT_W-1:0] ana);
    logic [PORT_W-1:0] r;
    r = (~dir & lat) | (dir & ~ana & pin);
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // Pin input synchroniser
  // ---------------------------------------------------------------------------
  ppc_pin_sync #(
    .WIDTH(NUM_PORTS * PORT_W)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // ---------------------------------------------------------------------------
  // Write merge
  // ---------------------------------------------------------------------------
  ppc_wr_if wr_bus();

  assign wr_bus.bit_access = bus_bit;
  assign wr_bus.bit_sel = bus_bit_sel;
  assign wr_bus.wdata = bus_wdata;

  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    ppc_byte_merge u_dir (
      .wr(wr_bus.dst),
      .old_val(cur.dir[g]),
      .mask(DIR_MASK[g]),
      .new_val(dir_new[g])
    );
    ppc_byte_merge u_lat (
      .wr(wr_bus.dst),
      .old_val(cur.lat[g]),
      .mask(LAT_MASK[g]),
      .new_val(lat_new[g])
    );
    ppc_byte_merge u_pu (
      .wr(wr_bus.dst),
      .old_val(cur.pu[g]),
      .mask(PU_MASK[g]),
      .new_val(pu_new[g])
    );

    // -------------------------------------------------------------------------
    // Pin behaviour
    // -------------------------------------------------------------------------
    assign dir_eff[g] = eff_dir(cur.dir[g], DIR_MASK[g], DIR_FIX[g]);
    if (g == P1_IDX) begin : g_pom
      assign open_drain[g] = OD_FIX[g] | (cur.pom & PORT1_OUTPUT_DRIVE_SELECT_MASK);
    end else begin : g_fix
      assign open_drain[g] = OD_FIX[g];
    end
    assign pin_out[g] = drive_level(cur.lat[g], open_drain[g]);
    assign pin_oe_b[g] = drive_off_b(dir_eff[g], open_drain[g], cur.lat[g]);
    assign pin_pullup[g] = pull_on(cur.pu[g] & PU_MASK[g], dir_eff[g], open_drain[g],
                                   analog_select_bit[g] | alt_out_active[g]);
    assign rd_port[g] = RD_MASK[g] & read_back(dir_eff[g], cur.lat[g], pin_sync[g],
                                               analog_select_bit[g]);
  end

  ppc_byte_merge u_pim (
    .wr(wr_bus.dst),
    .old_val(cur.pim),
    .mask(PORT1_INPUT_BUFFER_SELECT_MASK),
    .new_val(pim_new)
  );
  ppc_byte_merge u_pom (
    .wr(wr_bus.dst),
    .old_val(cur.pom),
    .mask(PORT1_OUTPUT_DRIVE_SELECT_MASK),
    .new_val(pom_new)
  );

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_val = 8'h00;
    case (kind)
      REG_DATA: begin
        rd_val = rd_port[hit_idx];
      end
      REG_DIR: begin
        rd_val = cur.dir[hit_idx] | ~DIR_MASK[hit_idx];
      end
      REG_PU: begin
        rd_val = cur.pu[hit_idx];
      end
      REG_PIM: begin
        rd_val = cur.pim;
      end
      REG_POM: begin
        rd_val = cur.pom;
      end
      REG_NONE: begin
        rd_val = 8'h00;
      end
      default: begin
        rd_val = 8'h00;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Register update
  // ---------------------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.rvalid = bus_rd;
    if (bus_wr) begin
      case (kind)
        REG_DATA: begin
          next_cur.lat[hit_idx] = lat_new[hit_idx];
        end
        REG_DIR: begin
          next_cur.dir[hit_idx] = dir_new[hit_idx];
        end
        REG_PU: begin
          next_cur.pu[hit_idx] = pu_new[hit_idx];
        end
        REG_PIM: begin
          next_cur.pim = pim_new;
        end
        REG_POM: begin
          next_cur.pom = pom_new;
        end
        default: begin
        end
      endcase
    end
    if (bus_rd) begin
      next_cur.rdata = rd_val;
    end
    if (!rst_b) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        next_cur.dir[p] = DIR_RST;
        next_cur.lat[p] = LAT_RST;
        next_cur.pu[p] = PU_RST[p];
      end
      next_cur.pim = PORT1_INPUT_BUFFER_SELECT_RST;
      next_cur.pom = PORT1_OUTPUT_DRIVE_SELECT_RST;
      next_cur.rdata = RDATA_RST;
      next_cur.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    cur <= next_cur;
  end

  assign bus_rdata = cur.rdata;
  assign bus_rvalid = cur.rvalid;
  assign input_buffer_type_bit = cur.pim;
endmodule // ppc_port_control

// ### test/ppc_assertions.sv
// Concurrent checks on the port pin control top-level ports.
// Assumes it is bound to ppc_port_control and sees only its ports.
`timescale 1ns/100ps
module ppc_assertions (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ppc_pkg::ADDR_W-1:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_bit,
  input wire logic [2:0] bus_bit_sel,
  input wire logic [ppc_pkg::PORT_W-1:0] bus_wdata,
  input wire logic [ppc_pkg::PORT_W-1:0] bus_rdata,
  input wire logic bus_rvalid,
  input wire ppc_pkg::ppc_port_bus_t pin_in,
  input wire ppc_pkg::ppc_port_bus_t pin_out,
  input wire ppc_pkg::ppc_port_bus_t pin_oe_b,
  input wire ppc_pkg::ppc_port_bus_t pin_pullup,
  input wire ppc_pkg::ppc_port_bus_t analog_select_bit,
  input wire ppc_pkg::ppc_port_bus_t alt_out_active,
  input wire logic [ppc_pkg::PORT_W-1:0] input_buffer_type_bit
);
  import ppc_pkg::*;
  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  AST_RD_PULSE: assert property (bus_rd |=> bus_rvalid)
    else $error("Read strobe gave no valid pulse.");
  AST_RD_QUIET: assert property (!bus_rd |=> !bus_rvalid && $stable(bus_rdata))
    else $error("Read data moved without a read.");
  AST_UNMAPPED: assert property (bus_rd && bus_addr == 20'hf0000 |=> bus_rdata == 8'h00)
    else $error("Unmapped read was not zero.");
  AST_DIR_BYTE: assert property (bus_wr && !bus_bit && bus_addr == 20'hfff22
    |=> pin_oe_b[1][1:0] == $past(bus_wdata[1:0]))
    else $error("Port two enables do not follow direction write.");
  AST_LAT_BYTE: assert property (bus_wr && !bus_bit && bus_addr == 20'hfff02
    |=> pin_out[1][1:0] == $past(bus_wdata[1:0]))
    else $error("Port two drive does not follow latch write.");
  AST_PU_GATE: assert property ((pin_pullup & (~pin_oe_b | analog_select_bit | alt_out_active)) == '0)
    else $error("Pull-up on a driving, analog or alternate pin.");
  AST_OD_LOW: assert property ((pin_out[5][1:0] & ~pin_oe_b[5][1:0]) == 2'h0)
    else $error("Open-drain pin drives high.");
  AST_OUTPUT_ONLY_PIN_OUT: assert property (pin_oe_b[8][0] == 1'b0)
    else $error("Output-only pin not driving.");
  AST_TTL_SEL: assert property ((input_buffer_type_bit & 8'h9c) == 8'h00)
    else $error("Buffer select on a pin without one.");
endmodule // ppc_assertions

bind ppc_port_control ppc_assertions i_chk (
  .clk(clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_bit(bus_bit), .bus_bit_sel(bus_bit_sel), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .bus_rvalid(bus_rvalid), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
  .pin_pullup(pin_pullup), .analog_select_bit(analog_select_bit),
  .alt_out_active(alt_out_active), .input_buffer_type_bit(input_buffer_type_bit));

// ### test/ppc_pin_model.sv
// External devices on the port pins, resolving each pin level.
// Assumes the port wins while driving, then an enabled device; a free pin floats to a toggling value unless pulled up.
`timescale 1ns/100ps
module ppc_pin_model (
  input wire logic clk,
  input wire ppc_pkg::ppc_port_bus_t pin_out,
  input wire ppc_pkg::ppc_port_bus_t pin_oe_b,
  input wire ppc_pkg::ppc_port_bus_t pin_pullup,
  input wire ppc_pkg::ppc_port_bus_t ext_val,
  input wire ppc_pkg::ppc_port_bus_t ext_en,
  output ppc_pkg::ppc_port_bus_t pin_level
);
  import ppc_pkg::*;
  // ---------------------------------------------------------------------------
  // Model
  // ---------------------------------------------------------------------------
  logic flt = 1'b0;
  always @(posedge clk) begin
    flt <= ~flt;
  end
  assign pin_level = (~pin_oe_b & pin_out) | (pin_oe_b & ext_en & ext_val)
    | (pin_oe_b & ~ext_en & (pin_pullup | {80{flt}}));
endmodule // ppc_pin_model

// ### test/ppc_port_control_tb_top.sv
// Directed register and pin tests for the port pin control block.
// Assumes ppc_pin_model on the pins and the checker bound to the design.
`timescale 1ns/100ps
module ppc_port_control_tb_top;
  import ppc_pkg::*;
  // ---------------------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------------------
  logic clk, rst_b, bus_wr, bus_rd, bus_bit, bus_rvalid;
  logic [2:0] bus_bit_sel;
  logic [19:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, ttl;
  ppc_port_bus_t pin_in, pin_out, pin_oe_b, pin_pullup, analog, alt, ext_val, ext_en, exp_oe;
  int n_errors = 0;
  int n_checks = 0;
  logic [19:0] ra [19] = '{20'hfff21, 20'hfff22, 20'hfff23, 20'hfff24, 20'hfff25, 20'hfff26,
    20'hfff27, 20'hfff2c, 20'hfff2e, 20'hf0031, 20'hf0033, 20'hf0034, 20'hf0035, 20'hf0037,
    20'hf003c, 20'hf003e, 20'hf0041, 20'hf0051, 20'hf0000};
  logic [7:0] re [19] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  ppc_port_control i_dut (.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_bit(bus_bit), .bus_bit_sel(bus_bit_sel), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_b(pin_oe_b), .pin_pullup(pin_pullup), .analog_select_bit(analog),
    .alt_out_active(alt), .input_buffer_type_bit(ttl));
  ppc_pin_model i_pins (.clk(clk), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
    .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en), .pin_level(pin_in));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [79:0] seen, input logic [79:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic b, input int s);
    bus_addr = a;
    bus_wdata = d;
    bus_bit = b;
    bus_bit_sel = 3'(s);
    bus_wr = 1'b1;
    @(negedge clk);
    bus_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [19:0] a, input logic [7:0] e);
    int k;
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clk);
    bus_rd = 1'b0;
    k = 0;
    while (bus_rvalid !== 1'b1 && k < 4) begin
      @(negedge clk);
      k++;
    end
    if (k == 4) begin
      n_errors++;
      results();
    end else begin
      check("rdata", bus_rdata, e);
      @(negedge clk);
    end
  endtask

  task automatic settle();
    repeat (6) @(negedge clk);
  endtask

  initial begin
    {rst_b, bus_wr, bus_rd, bus_bit, bus_bit_sel, bus_addr, bus_wdata} = '0;
    {analog, alt, ext_val} = '0;
    ext_en = '1;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    exp_oe = '1;
    exp_oe[8][0] = 1'b0;
    check("pin_out", pin_out, '0);
    check("pin_oe_b", pin_oe_b, exp_oe);
    for (int i = 0; i < 19; i++) rd(ra[i], re[i]);
    wr(20'hfff21, 8'h0f, 1'b0, 0);
    wr(20'hfff21, 8'h01, 1'b1, 7);
    rd(20'hfff21, 8'h8f);
    wr(20'hfff22, 8'h00, 1'b0, 0);
    rd(20'hfff22, 8'hfc);
    wr(20'hf0033, 8'hff, 1'b0, 0);
    rd(20'hf0033, 8'h07);
    wr(20'hf0041, 8'hff, 1'b0, 0);
    rd(20'hf0041, 8'h63);
    check("ttl", ttl, 8'h63);
    wr(20'hf0051, 8'hff, 1'b0, 0);
    rd(20'hf0051, 8'ha5);
    wr(20'hf0051, 8'h00, 1'b0, 0);
    wr(20'hf0000, 8'hff, 1'b0, 0);
    rd(20'hf0000, 8'h00);
    wr(20'hfff02, 8'h02, 1'b0, 0);
    check("p2_out", pin_out[1][1:0], 2'h2);
    check("p2_oe", pin_oe_b[1][1:0], 2'h0);
    wr(20'hfff26, 8'h00, 1'b0, 0);
    wr(20'hfff06, 8'h03, 1'b0, 0);
    check("p6_oe", pin_oe_b[5][1:0], 2'h3);
    settle();
    rd(20'hfff06, 8'h03);
    wr(20'hfff06, 8'h00, 1'b0, 0);
    check("p6_oe", pin_oe_b[5][1:0], 2'h0);
    ext_val[2] = 8'h05;
    settle();
    rd(20'hfff03, 8'h05);
    analog[2][0] = 1'b1;
    settle();
    rd(20'hfff03, 8'h04);
    check("p3_pu", pin_pullup[2][2:0], 3'h6);
    alt[2][1] = 1'b1;
    @(negedge clk);
    check("p3_pu", pin_pullup[2][2:0], 3'h4);
    {analog, alt} = '0;
    @(negedge clk);
    check("p3_pu", pin_pullup[2][2:0], 3'h7);
    wr(20'hfff23, 8'h00, 1'b1, 2);
    check("p3_pu", pin_pullup[2][2:0], 3'h3);
    ext_en[2] = 8'h00;
    settle();
    rd(20'hfff03, 8'h03);
    wr(20'hf0031, 8'h01, 1'b0, 0);
    check("p1_pu", pin_pullup[0][0], 1'b1);
    wr(20'hf0051, 8'h01, 1'b1, 0);
    check("p1_pu", pin_pullup[0][0], 1'b0);
    wr(20'hfff0d, 8'hff, 1'b0, 0);
    check("output_only_pin", pin_out[8][0], 1'b1);
    settle();
    rd(20'hfff0d, 8'h01);
    results();
  end
endmodule // ppc_port_control_tb_top
